//--- rtl/efr_core.sv
// Notes on behaviour
// - Power-good low after power-up; asserts one deglitch after gate reaches full drive.
// - Output droop below threshold removes power-good after the same deglitch.
// - Power-good starts handshake timer; trip before load pulls low gives handshake fault.
// - Load keeps handshake low; release restarts timer and trip shuts output.
// - After handshake fault, handshake low, supply cycle or enable cycle clears it; output restarts only with handshake low.
// - Enable low disables; enable high with handshake low is on, high is off.
// - Overtemperature, breaker, blanking-pin or limit-pin short raises a fault, output off.
// - With no retry left or retry disabled, fault stays latched with output off after the cause clears until enable or supply drops.
// - Supply below falling threshold or enable below shutdown clears the fault latch.
// - Delay strap shorted means no auto-retry, always latched off.
// - Delay open, count open: four retries at minimum delay, then latch.
// - Delay open, count shorted: endless retries at minimum delay.
// - Both capacitors: programmed delay and quantized programmed count, then latch.
// - Delay capacitor, count open: four retries at programmed delay, then latch.
// - Delay capacitor, count shorted: endless retries at programmed delay.
// - Retry delay is 128 oscillator charge and discharge phases.
// - Raw retry count is four times count timing over delay timing.
// - Raw count rounds up to 4, 16, 64, 256 or 1024.
// - Seven quiet retry-delay periods after the last fault reset the retry counter.
`timescale 1ns/1ps
`default_nettype none
module efr_core #(
  parameter int HANDSHAKE_TRIP_CYC = efr_pkg::HANDSHAKE_TRIP_CYC_DEF,
  parameter int PW = 24
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_undervoltage_in,
  input wire logic supply_ok_in,
  input wire logic gate_full_in,
  input wire logic output_droop_in,
  input wire logic load_handshake_line_in,
  input wire logic overtemp_in,
  input wire logic breaker_trip_in,
  input wire logic blanking_pin_short_in,
  input wire logic limit_pin_short_in,
  input wire logic [1:0] retry_delay_strap_in,
  input wire logic [1:0] retry_count_strap_in,
  input wire logic [PW-1:0] delay_phase_cycles_in,
  input wire logic [PW-1:0] count_phase_cycles_in,
  output logic switch_on_out,
  output logic power_good_out,
  output logic fault_latched_out,
  output logic handshake_fault_out,
  output logic [10:0] retry_count_out
);
  localparam logic [31:0] DEGL = 32'(efr_pkg::GOOD_DEGLITCH_CYC);
  localparam logic [31:0] HTRIP = 32'(HANDSHAKE_TRIP_CYC);

  // Every pin-level input except the straps and phase counts is double-registered; only stage two is read.
  localparam int NS = 9;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;
  assign raw_in = {enable_undervoltage_in, supply_ok_in, gate_full_in, output_droop_in,
                   load_handshake_line_in, overtemp_in, breaker_trip_in,
                   blanking_pin_short_in, limit_pin_short_in};
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end
  wire en_s = sync_b[8];
  wire sup_s = sync_b[7];
  wire gate_s = sync_b[6];
  wire droop_s = sync_b[5];
  wire hs_high = sync_b[4];
  wire any_fault = |sync_b[3:0];
  wire run_ok = en_s && sup_s;

  function automatic logic [10:0] quantize(input logic [31:0] raw);
    if (raw <= 32'(efr_pkg::RETRY_LVL0)) quantize = efr_pkg::RETRY_LVL0;
    else if (raw <= 32'(efr_pkg::RETRY_LVL1)) quantize = efr_pkg::RETRY_LVL1;
    else if (raw <= 32'(efr_pkg::RETRY_LVL2)) quantize = efr_pkg::RETRY_LVL2;
    else if (raw <= 32'(efr_pkg::RETRY_LVL3)) quantize = efr_pkg::RETRY_LVL3;
    else quantize = efr_pkg::RETRY_LVL4;
  endfunction

  // Retry policy decode from the straps.
  wire no_retry = retry_delay_strap_in == efr_pkg::STRAP_SHORT;
  wire delay_cap = retry_delay_strap_in == efr_pkg::STRAP_CAP;
  wire endless = retry_count_strap_in == efr_pkg::STRAP_SHORT;
  wire count_cap = delay_cap && retry_count_strap_in == efr_pkg::STRAP_CAP;
  wire [PW-1:0] phase_len = delay_cap ? delay_phase_cycles_in :
                            PW'(efr_pkg::MIN_DELAY_PHASE_CYC);
  // A combinational divider is used because the straps are static: the quotient
  // settles long before a fault needs it, at the cost of a long timing path.
  // It is rounded up so that a ratio just above a level selects the next level.
  wire delay_phases_ok = delay_phase_cycles_in != '0;
  wire [PW-1:0] phase_nz = delay_phases_ok ? delay_phase_cycles_in : PW'(1);
  wire [31:0] ratio_raw = delay_phases_ok ?
      (32'(efr_pkg::RAW_COUNT_SCALE) * 32'(count_phase_cycles_in) + 32'(phase_nz) -
       32'h0000_0001) / 32'(phase_nz) : 32'h0000_0000;
  wire [10:0] retry_limit = count_cap ? quantize(ratio_raw) :
                            11'(efr_pkg::FIXED_RETRIES);

  efr_pkg::efr_state_e state;
  efr_pkg::efr_state_e next_state;
  logic [PW-1:0] phase_cnt;
  logic [7:0] phase_num;
  logic [2:0] quiet_periods;
  logic [31:0] hs_cnt;
  logic [31:0] pg_cnt;
  logic en_prev;
  logic sup_prev;
  logic [10:0] retries;

  wire hs_trip = hs_cnt >= HTRIP;
  wire delay_done = phase_cnt == phase_len - PW'(1) &&
                    phase_num == 8'(efr_pkg::DELAY_PHASES - 1);
  wire period_tick = phase_cnt == phase_len - PW'(1);
  wire cycle_event = (en_prev && !en_s) || (sup_prev && !sup_s);
  wire hs_restart = handshake_fault_out && !hs_high && run_ok;
  wire retry_left = endless || retries < retry_limit;

  always_comb begin
    next_state = state;
    unique case (state)
      efr_pkg::EFR_OFF:
        if (run_ok && !any_fault && !hs_high) next_state = efr_pkg::EFR_ON;
      efr_pkg::EFR_ON:
        if (!run_ok) next_state = efr_pkg::EFR_OFF;
        else if (any_fault) next_state = efr_pkg::EFR_FAULT;
        else if (hs_trip) next_state = efr_pkg::EFR_OFF;
      efr_pkg::EFR_FAULT:
        if (!run_ok) next_state = efr_pkg::EFR_OFF;
        else if (!no_retry && retry_left) next_state = efr_pkg::EFR_WAIT;
      efr_pkg::EFR_WAIT:
        if (!run_ok) next_state = efr_pkg::EFR_OFF;
        else if (delay_done) next_state = any_fault ? efr_pkg::EFR_FAULT : efr_pkg::EFR_ON;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= efr_pkg::EFR_OFF;
      en_prev <= 1'b0;
      sup_prev <= 1'b0;
    end else begin
      state <= next_state;
      en_prev <= en_s;
      sup_prev <= sup_s;
    end
  end

  // Handshake fault: held until handshake low, supply cycle or enable cycle.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) handshake_fault_out <= 1'b0;
    else if (state == efr_pkg::EFR_ON && run_ok && !any_fault && hs_trip)
      handshake_fault_out <= 1'b1;
    else if (hs_restart || cycle_event || !run_ok) handshake_fault_out <= 1'b0;
  end

  // While handshake fault holds, EFR_OFF waits for the line to fall again.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) hs_cnt <= '0;
    else if (!power_good_out || !hs_high) hs_cnt <= '0;
    else if (!hs_trip) hs_cnt <= hs_cnt + 32'h0000_0001;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) switch_on_out <= 1'b0;
    else switch_on_out <= next_state == efr_pkg::EFR_ON;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) fault_latched_out <= 1'b0;
    else if (next_state == efr_pkg::EFR_FAULT) fault_latched_out <= 1'b1;
    else if (next_state != efr_pkg::EFR_WAIT) fault_latched_out <= 1'b0;
  end

  // Deglitch: the wanted power-good level must stand for the full count.
  // Droop also blocks the first assertion, so a sagging output never shows good.
  wire pg_want = state == efr_pkg::EFR_ON && switch_on_out && gate_s && !droop_s;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pg_cnt <= '0;
      power_good_out <= 1'b0;
    end else if (next_state != efr_pkg::EFR_ON) begin
      pg_cnt <= '0;
      power_good_out <= 1'b0;
    end else if (pg_want == power_good_out) begin
      pg_cnt <= '0;
    end else if (pg_cnt >= DEGL - 32'h0000_0001) begin
      pg_cnt <= '0;
      power_good_out <= pg_want;
    end else begin
      pg_cnt <= pg_cnt + 32'h0000_0001;
    end
  end

  // Delay oscillator: phase_len cycles per charge or discharge phase.
  wire phase_rst = state == efr_pkg::EFR_ON && any_fault;
  wire full_period = period_tick && phase_num == 8'(efr_pkg::DELAY_PHASES - 1);
  // The phase number wraps at the period length so each period is seen once.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || state == efr_pkg::EFR_FAULT || phase_rst) begin
      phase_cnt <= '0;
      phase_num <= '0;
    end else if (period_tick) begin
      phase_cnt <= '0;
      phase_num <= full_period ? 8'h00 : phase_num + 8'h01;
    end else begin
      phase_cnt <= phase_cnt + PW'(1);
    end
  end

  // Quiet timer counts whole delay periods while running fault-free.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      retries <= '0;
      quiet_periods <= '0;
    end else if (cycle_event || !run_ok) begin
      retries <= '0;
      quiet_periods <= '0;
    end else if (state == efr_pkg::EFR_FAULT && next_state == efr_pkg::EFR_WAIT) begin
      retries <= retries + 11'h001;
      quiet_periods <= '0;
    end else if (state == efr_pkg::EFR_ON && full_period) begin
      if (quiet_periods == 3'(efr_pkg::QUIET_PERIODS - 1)) begin
        retries <= '0;
        quiet_periods <= '0;
      end else begin
        quiet_periods <= quiet_periods + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) retry_count_out <= '0;
    else retry_count_out <= retries;
  end

  property p_pg_low_off;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      !switch_on_out |=> !power_good_out;
  endproperty
  a_pg_low_off: assert property (p_pg_low_off) else $error("power good while off");
  property p_pg_deglitch;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      $rose(power_good_out) |-> $past(gate_s, 2) && switch_on_out;
  endproperty
  a_pg_deglitch: assert property (p_pg_deglitch) else $error("power good early");
  property p_pg_droop;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      $fell(power_good_out) && switch_on_out |-> $past(droop_s || !gate_s);
  endproperty
  a_pg_droop: assert property (p_pg_droop) else $error("power good fell without cause");
  property p_hs_fault;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      $rose(handshake_fault_out) |-> !switch_on_out;
  endproperty
  a_hs_fault: assert property (p_hs_fault) else $error("handshake fault left output on");
  property p_fault_off;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      fault_latched_out |-> !switch_on_out;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("output on with fault latched");
  property p_enable_off;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      !en_s |=> !switch_on_out;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("on while disabled");
  property p_no_retry;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      no_retry |-> state != efr_pkg::EFR_WAIT;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retry with shorted strap");
  property p_limit;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      !endless |-> retries <= retry_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("retries over limit");
  property p_clear;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      !run_ok |=> !fault_latched_out;
  endproperty
  a_clear: assert property (p_clear) else $error("latch not cleared");
  c_pg: cover property (@(posedge core_clk_in) $rose(power_good_out));
  c_hs: cover property (@(posedge core_clk_in) $rose(handshake_fault_out));
  c_retry: cover property (@(posedge core_clk_in) $rose(state == efr_pkg::EFR_WAIT));
  c_fault: cover property (@(posedge core_clk_in) $rose(fault_latched_out));
  c_quiet: cover property (@(posedge core_clk_in) state == efr_pkg::EFR_ON && full_period &&
    quiet_periods == 3'(efr_pkg::QUIET_PERIODS - 1));

  property p_hs_trip_off;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_ON && run_ok && !any_fault && hs_trip |=>
        handshake_fault_out && !switch_on_out;
  endproperty
  a_hs_trip_off: assert property (p_hs_trip_off) else $error("trip ignored");
  property p_hs_timer;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      !hs_high |=> hs_cnt == 32'h0000_0000;
  endproperty
  a_hs_timer: assert property (p_hs_timer) else $error("timer not restarted");
  property p_hs_restart;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      handshake_fault_out && !hs_high && run_ok |=> !handshake_fault_out;
  endproperty
  a_hs_restart: assert property (p_hs_restart) else $error("handshake fault stuck");
  property p_fault_shut;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_ON && run_ok && any_fault |=>
        fault_latched_out && !switch_on_out;
  endproperty
  a_fault_shut: assert property (p_fault_shut) else $error("fault did not shut down");
  property p_endless;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_FAULT && endless && !no_retry && run_ok |=>
        state == efr_pkg::EFR_WAIT;
  endproperty
  a_endless: assert property (p_endless) else $error("endless retry stopped");

  // Checker helper: cycles spent so far in the current retry wait.
  logic [31:0] wait_cyc;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || state != efr_pkg::EFR_WAIT) wait_cyc <= '0;
    else wait_cyc <= wait_cyc + 32'h0000_0001;
  end
  property p_wait_len;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_WAIT && next_state != efr_pkg::EFR_WAIT && run_ok |->
        wait_cyc == 32'(efr_pkg::DELAY_PHASES) * 32'(phase_len) - 32'h0000_0001;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("retry delay wrong");
  property p_quiet;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_ON && full_period &&
        quiet_periods == 3'(efr_pkg::QUIET_PERIODS - 1) |=> retries == 11'h000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("retries kept after quiet time");
  property p_retry_step;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_FAULT && next_state == efr_pkg::EFR_WAIT |=>
        retries == $past(retries) + 11'h001;
  endproperty
  a_retry_step: assert property (p_retry_step) else $error("retry not counted");
  property p_retry_on;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      state == efr_pkg::EFR_WAIT && delay_done && run_ok && !any_fault |=>
        switch_on_out && !fault_latched_out;
  endproperty
  a_retry_on: assert property (p_retry_on) else $error("retry left output off");
endmodule
`default_nettype wire

//--- rtl/efr_pkg.sv
package efr_pkg;
  // Strap condition codes presented by the analog strap sensing.
  localparam logic [1:0] STRAP_SHORT = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_CAP = 2'h2;
  localparam int CLK_MHZ = 250;
  localparam int GOOD_DEGLITCH_US = 2;
  localparam int GOOD_DEGLITCH_CYC = (GOOD_DEGLITCH_US * CLK_MHZ < 1) ? 1 :
                                     GOOD_DEGLITCH_US * CLK_MHZ;
  localparam int HANDSHAKE_TRIP_CYC_DEF = 1000;
  localparam int MIN_DELAY_PHASE_CYC = 16;
  localparam int DELAY_PHASES = 128;
  localparam int RAW_COUNT_SCALE = 4;
  localparam int QUIET_PERIODS = 7;
  localparam int FIXED_RETRIES = 4;
  localparam logic [10:0] RETRY_LVL0 = 11'h004;
  localparam logic [10:0] RETRY_LVL1 = 11'h010;
  localparam logic [10:0] RETRY_LVL2 = 11'h040;
  localparam logic [10:0] RETRY_LVL3 = 11'h100;
  localparam logic [10:0] RETRY_LVL4 = 11'h400;
  typedef enum logic [1:0] {
    EFR_OFF = 2'b00,
    EFR_ON = 2'b01,
    EFR_FAULT = 2'b10,
    EFR_WAIT = 2'b11
  } efr_state_e;
endpackage

//--- tb/efr_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module efr_core_tb;
  localparam int TRIP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic gate = 1'b1;
  logic droop = 1'b0;
  logic present = 1'b1;
  logic sup = 1'b1;
  logic [3:0] flt = 4'h0;
  logic [1:0] dly_s = efr_pkg::STRAP_SHORT;
  logic [1:0] cnt_s = efr_pkg::STRAP_OPEN;
  logic [23:0] dph = 24'h00_0004;
  logic [23:0] cph = 24'h00_000c;
  logic hs, sw, pg, fl, hf;
  logic [10:0] rc;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 92;
  always #2 clk = ~clk;
  efr_core #(.HANDSHAKE_TRIP_CYC(TRIP), .PW(24)) i_efr_core (
    .core_clk_in(clk), .sys_rst_in(rst), .enable_undervoltage_in(en), .supply_ok_in(sup),
    .gate_full_in(gate), .output_droop_in(droop), .load_handshake_line_in(hs),
    .overtemp_in(flt[0]), .breaker_trip_in(flt[1]), .blanking_pin_short_in(flt[2]),
    .limit_pin_short_in(flt[3]), .retry_delay_strap_in(dly_s), .retry_count_strap_in(cnt_s),
    .delay_phase_cycles_in(dph), .count_phase_cycles_in(cph), .switch_on_out(sw),
    .power_good_out(pg), .fault_latched_out(fl), .handshake_fault_out(hf),
    .retry_count_out(rc));
  efr_load_model i_efr_load_model (.core_clk_in(clk), .present_in(present),
    .handshake_line_out(hs));
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [10:0] cur(input int sel);
    case (sel)
      0: return {10'h000, sw};
      1: return {10'h000, pg};
      2: return {10'h000, fl};
      3: return {10'h000, hf};
      default: return rc;
    endcase
  endfunction
  // Every wait is bounded; running out of time ends the run as a failure.
  task automatic wt(input int sel, input logic [10:0] val, input int lim);
    int k;
    k = 0;
    while (cur(sel) !== val && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk(cur(sel), val);
    if (cur(sel) !== val) final_report();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reference for the quantised retry count and the retry delay in cycles.
  function automatic int exp_n(input logic [1:0] ds, input logic [1:0] cs);
    int lv[5] = '{4, 16, 64, 256, 1024};
    int raw;
    if (ds == efr_pkg::STRAP_SHORT) return 0;
    if (cs != efr_pkg::STRAP_CAP) return 4;
    raw = (4 * int'(cph) + int'(dph) - 1) / int'(dph);
    foreach (lv[i]) if (lv[i] >= raw) return lv[i];
    return 1024;
  endfunction
  function automatic int exp_dly(input logic [1:0] ds);
    if (ds == efr_pkg::STRAP_OPEN) return efr_pkg::MIN_DELAY_PHASE_CYC * 128;
    return int'(dph) * 128;
  endfunction
  task automatic run(input logic [1:0] ds, input logic [1:0] cs, input int idx);
    int n;
    int d;
    @(posedge clk);
    en <= 1'b0;
    flt <= 4'h0;
    dph <= 24'(2 + $unsigned($random(seed)) % 4);
    tick(4);
    cph <= 24'(1 + $unsigned($random(seed)) % (4 * int'(dph)));
    dly_s <= ds;
    cnt_s <= cs;
    en <= 1'b1;
    @(negedge clk);
    n = exp_n(ds, cs);
    d = exp_dly(ds);
    wt(0, 1, 20);
    @(posedge clk);
    flt <= 4'h1 << idx[1:0];
    wt(2, 1, 40);
    chk(sw, 0);
    if (n == 0) begin
      @(posedge clk);
      flt <= 4'h0;
      tick(3000);
      @(negedge clk);
      chk(fl, 1);
      chk(rc, 0);
      chk(sw, 0);
      @(posedge clk);
      en <= 1'b0;
      wt(2, 0, 10);
    end else if (cs == efr_pkg::STRAP_SHORT) begin
      wt(4, 5, 6 * d);
      @(posedge clk);
      flt <= 4'h0;
      wt(0, 1, d + 100);
      wt(4, 0, 8 * d + 200);
    end else begin
      wt(4, 11'(n), (n + 1) * d + 500);
      tick(d + 500);
      @(negedge clk);
      chk(rc, 11'(n));
      chk(fl, 1);
    end
  endtask
  logic [1:0] tds[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  logic [1:0] tcs[6] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
  initial begin
    tick(2);
    rst <= 1'b0;
    gate <= 1'b0;
    @(negedge clk);
    chk(pg, 0);
    @(posedge clk);
    en <= 1'b1;
    wt(0, 1, 20);
    @(posedge clk);
    gate <= 1'b1;
    tick(450);
    @(negedge clk);
    chk(pg, 0);
    wt(1, 1, 100);
    @(posedge clk);
    droop <= 1'b1;
    tick(450);
    @(negedge clk);
    chk(pg, 1);
    wt(1, 0, 100);
    @(posedge clk);
    droop <= 1'b0;
    present <= 1'b0;
    wt(3, 1, efr_pkg::GOOD_DEGLITCH_CYC + TRIP + 40);
    chk(sw, 0);
    @(posedge clk);
    present <= 1'b1;
    wt(0, 1, 20);
    chk(hf, 0);
    for (int i = 0; i < 6; i++) run(tds[i], tcs[i], i);
    @(posedge clk);
    en <= 1'b0;
    wt(0, 0, 10);
    final_report();
  end
endmodule
`default_nettype wire

//--- tb/efr_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// The load pulls the line low while present; once released the device pull-up lifts it.
module efr_load_model (
  input wire logic core_clk_in,
  input wire logic present_in,
  output logic handshake_line_out
);
  always_ff @(posedge core_clk_in) begin
    handshake_line_out <= ~present_in;
  end
endmodule
`default_nettype wire
